// >>> rtl/adc_map.svh
// Purpose: Constants of the converter's two-wire slave port
// Assumes: 50 MHz system clock
// Notes:   Threshold reset values are plain defaults
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH
`define ADC_PTR_RESULT 2'h0
`define ADC_PTR_CFG    2'h1
`define ADC_PTR_LOW    2'h2
`define ADC_PTR_HIGH   2'h3
`define ADC_PTR_LSB    0
`define ADC_RW_BIT     0
`define ADC_ADDR_BASE  5'h12
`define ADC_GC_ADDR    8'h00
`define ADC_GC_RESET   8'h06
`define ADC_HS_CODE    5'h01
`define ADC_RES_RST    24'h00_0000
`define ADC_RES_POS_FS 24'h7F_FFFF
`define ADC_RES_NEG_FS 24'h80_0000
`define ADC_CFG_RST    16'h8583
`define ADC_LOW_RST    16'h8000
`define ADC_HIGH_RST   16'h7FFF
`define ADC_IDLE_BYTE  8'hFF
`define ADC_TIMEOUT_MS 25
`define ADC_CLK_KHZ    50000
`endif

// >>> rtl/adc_pkg.sv
// Purpose: Types of the converter's two-wire slave port
// Assumes: Nothing
// Notes:   Whole port state travels as one struct
package adc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100,
    ST_ACKR = 3'b101,
    ST_LOAD = 3'b110,
    ST_SKIP = 3'b111
  } adc_state_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] low;
    logic [15:0] high;
  } adc_regs_t;

  typedef struct packed {
    adc_state_t  state;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        gc;
    logic [1:0]  byte_idx;
    logic [1:0]  ptr;
    logic [7:0]  wr_hi;
    adc_regs_t   regs;
    logic [23:0] res;
    logic        sda_oe;
    logic        hs;
    logic        gc_rst;
    logic [31:0] idle_cnt;
  } adc_port_t;
endpackage

// >>> rtl/adc_i2c_slave.sv
// Purpose: Two-wire slave port of a 24-bit converter, four registers
// Assumes: Bus clock well below clk/8; lines sampled through two flops
// Notes:   Serial clock is never driven; data line is open drain
// Operation
// - Act only as slave; never drive the serial clock line.
// - Write: address with direction low, then pointer byte, which is acknowledged.
// - Two data bytes after the pointer go to the selected register, each acknowledged.
// - Register bytes travel most significant byte first in both directions.
// - Direction high: send selected register high byte first, master acknowledges each.
// - Master nack, start or stop ends a read; data line released.
// - Address plus pointer alone is a valid write.
// - Pointer bits kept until a later write changes them.
// - Reads return the register chosen by the last written pointer.
// - Result is 24-bit two's complement, full scale 7FFFFF and 800000.
// - Out-of-range inputs saturate at the full-scale codes.
// - Pointer 00 result, 01 config, 10 low limit, 11 high limit.
// - Result register is read-only; writes to it are ignored.
// - Result reads zero after reset until the first conversion.
// - Slave address 10010 plus two strap bits, sampled continuously.
// - General call acknowledged; second byte 06h resets registers, powers down; the code only reloads registers and pointer and pulses gc_reset.
// - High-speed master code not acknowledged; mode held until next stop.
// - Port returns to idle after 25 ms of bus inactivity.
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"
module adc_i2c_slave #(
  parameter int RAW_W       = 26,
  parameter int TIMEOUT_CYC = `ADC_TIMEOUT_MS * `ADC_CLK_KHZ
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output var  logic                    sda_o,
  output var  logic                    sda_oe,
  input  wire logic                    strap_bit_next,
  input  wire logic                    strap_bit_lsb,
  input  wire logic                    conv_valid,
  input  wire logic signed [RAW_W-1:0] conv_raw,
  output var  logic [23:0]             result,
  output var  adc_pkg::adc_regs_t      regs,
  output var  logic                    hs_mode,
  output var  logic                    gc_reset
);
  import adc_pkg::*;

  // Pin synchronisers; first stages feed only second stages
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic [1:0] strap_q0;
  logic [1:0] strap_q1;
  logic       scl_p;
  logic       sda_p;
  logic       sda_o_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q    <= 2'h3;
      sda_q    <= 2'h3;
      strap_q0 <= 2'h0;
      strap_q1 <= 2'h0;
      scl_p    <= 1'b1;
      sda_p    <= 1'b1;
      sda_o_r  <= 1'b0;
    end else if (ce) begin
      scl_q    <= {scl_q[0], scl_i};
      sda_q    <= {sda_q[0], sda_i};
      strap_q0 <= {strap_bit_next, strap_bit_lsb};
      strap_q1 <= strap_q0;
      scl_p    <= scl_q[1];
      sda_p    <= sda_q[1];
      sda_o_r  <= 1'b0;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_s    = scl_q[1];
  assign sda_s    = sda_q[1];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;

  adc_port_t s_r;
  adc_port_t s_nxt;

  // Byte offered to the master for the current pointer and byte index
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `ADC_IDLE_BYTE;
    case (s_r.ptr)
      `ADC_PTR_RESULT: begin
        case (s_r.byte_idx)
          2'h0:    rd_byte = s_r.res[23:16];
          2'h1:    rd_byte = s_r.res[15:8];
          2'h2:    rd_byte = s_r.res[7:0];
          default: rd_byte = `ADC_IDLE_BYTE;
        endcase
      end
      `ADC_PTR_CFG:  rd_byte = (s_r.byte_idx == 2'h0) ? s_r.regs.cfg[15:8] :
                               (s_r.byte_idx == 2'h1) ? s_r.regs.cfg[7:0] : `ADC_IDLE_BYTE;
      `ADC_PTR_LOW:  rd_byte = (s_r.byte_idx == 2'h0) ? s_r.regs.low[15:8] :
                               (s_r.byte_idx == 2'h1) ? s_r.regs.low[7:0] : `ADC_IDLE_BYTE;
      `ADC_PTR_HIGH: rd_byte = (s_r.byte_idx == 2'h0) ? s_r.regs.high[15:8] :
                               (s_r.byte_idx == 2'h1) ? s_r.regs.high[7:0] : `ADC_IDLE_BYTE;
      default:       rd_byte = `ADC_IDLE_BYTE;
    endcase
  end

  // Saturating result; overflow when the bits above 23 disagree with the sign
  logic [23:0] sat_res;
  logic        in_range;
  assign in_range = (&conv_raw[RAW_W-1:23]) | ~(|conv_raw[RAW_W-1:23]);
  assign sat_res  = in_range ? conv_raw[23:0] :
                    (conv_raw[RAW_W-1] ? `ADC_RES_NEG_FS : `ADC_RES_POS_FS);

  logic [6:0] own_addr;
  assign own_addr = {`ADC_ADDR_BASE, strap_q1};

  always_comb begin
    s_nxt        = s_r;
    s_nxt.gc_rst = 1'b0;
    if (conv_valid) begin
      s_nxt.res = sat_res;
    end
    if (s_r.state == ST_IDLE || scl_s != scl_p || sda_s != sda_p) begin
      s_nxt.idle_cnt = 32'h0000_0000;
    end else begin
      s_nxt.idle_cnt = s_r.idle_cnt + 32'h0000_0001;
    end
    if (stop_c) begin
      s_nxt.state  = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.hs     = 1'b0;
    end else if (start_c) begin
      s_nxt.state  = ST_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (s_r.idle_cnt > 32'(TIMEOUT_CYC)) begin
      s_nxt.state  = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.state)
        ST_ADDR: begin
          if (scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], sda_s};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == 4'h8) begin
            s_nxt.byte_idx = 2'h0;
            s_nxt.rw       = s_r.sh[`ADC_RW_BIT];
            s_nxt.gc       = 1'b0;
            if (s_r.sh[7:1] == own_addr) begin
              s_nxt.state  = ST_ACK;
              s_nxt.sda_oe = 1'b1;
            end else if (s_r.sh == `ADC_GC_ADDR) begin
              s_nxt.state  = ST_ACK;
              s_nxt.gc     = 1'b1;
              s_nxt.sda_oe = 1'b1;
            end else begin
              s_nxt.state = ST_SKIP;
              if (s_r.sh[7:3] == `ADC_HS_CODE) begin
                s_nxt.hs = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.rw) begin
              s_nxt.state  = ST_RD;
              s_nxt.sh     = rd_byte;
              s_nxt.sda_oe = ~rd_byte[7];
            end else begin
              s_nxt.state  = ST_WR;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], sda_s};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == 4'h8) begin
            s_nxt.state    = ST_ACK;
            s_nxt.sda_oe   = 1'b1;
            s_nxt.byte_idx = s_r.byte_idx + 2'h1;
            if (s_r.gc) begin
              if (s_r.byte_idx != 2'h0) begin
                s_nxt.state  = ST_SKIP;
                s_nxt.sda_oe = 1'b0;
              end else if (s_r.sh == `ADC_GC_RESET) begin
                s_nxt.regs.cfg  = `ADC_CFG_RST;
                s_nxt.regs.low  = `ADC_LOW_RST;
                s_nxt.regs.high = `ADC_HIGH_RST;
                s_nxt.ptr       = `ADC_PTR_RESULT;
                s_nxt.gc_rst    = 1'b1;
              end
            end else begin
              case (s_r.byte_idx)
                2'h0: s_nxt.ptr = s_r.sh[`ADC_PTR_LSB +: 2];
                2'h1: s_nxt.wr_hi = s_r.sh;
                2'h2: begin
                  case (s_r.ptr)
                    `ADC_PTR_CFG:  s_nxt.regs.cfg  = {s_r.wr_hi, s_r.sh};
                    `ADC_PTR_LOW:  s_nxt.regs.low  = {s_r.wr_hi, s_r.sh};
                    `ADC_PTR_HIGH: s_nxt.regs.high = {s_r.wr_hi, s_r.sh};
                    default:       s_nxt.regs      = s_r.regs;
                  endcase
                end
                default: begin
                  // Surplus bytes are refused rather than wrapped
                  s_nxt.state    = ST_SKIP;
                  s_nxt.sda_oe   = 1'b0;
                  s_nxt.byte_idx = s_r.byte_idx;
                end
              endcase
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_r.cnt == 4'h8) begin
              s_nxt.state  = ST_ACKR;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sh     = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.sh[6];
            end
          end
        end
        ST_ACKR: begin
          if (scl_rise) begin
            if (sda_s) begin
              s_nxt.state = ST_SKIP;
            end else begin
              s_nxt.state    = ST_LOAD;
              s_nxt.byte_idx = s_r.byte_idx + 2'h1;
            end
          end
        end
        ST_LOAD: begin
          if (scl_fall) begin
            s_nxt.state  = ST_RD;
            s_nxt.cnt    = 4'h0;
            s_nxt.sh     = rd_byte;
            s_nxt.sda_oe = ~rd_byte[7];
          end
        end
        ST_IDLE: s_nxt.sda_oe = 1'b0;
        ST_SKIP: s_nxt.sda_oe = 1'b0;
        default: s_nxt.state  = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r           <= '0;
      s_r.state     <= ST_IDLE;
      s_r.res       <= `ADC_RES_RST;
      s_r.regs.cfg  <= `ADC_CFG_RST;
      s_r.regs.low  <= `ADC_LOW_RST;
      s_r.regs.high <= `ADC_HIGH_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Serial clock has no output at all; only the data line is ever pulled
  assign sda_o    = sda_o_r;
  assign sda_oe   = s_r.sda_oe;
  assign result   = s_r.res;
  assign regs     = s_r.regs;
  assign hs_mode  = s_r.hs;
  assign gc_reset = s_r.gc_rst;

  logic ev_ok;
  assign ev_ok = ce & ~start_c & ~stop_c & (s_r.idle_cnt <= 32'(TIMEOUT_CYC));

  a_ptr_ack: assert property (@(posedge clk) disable iff (!arst_n)
    (ev_ok && s_r.state == ST_WR && scl_fall && s_r.cnt == 4'h8 && !s_r.gc
     && s_r.byte_idx == 2'h0) |=> (s_r.sda_oe && s_r.state == ST_ACK))
    else $error("pointer byte not acknowledged");

  a_foreign_nack: assert property (@(posedge clk) disable iff (!arst_n)
    (ev_ok && s_r.state == ST_ADDR && scl_fall && s_r.cnt == 4'h8
     && s_r.sh[7:1] != own_addr && s_r.sh != `ADC_GC_ADDR) |=> !s_r.sda_oe)
    else $error("foreign address acknowledged");

  a_read_nack: assert property (@(posedge clk) disable iff (!arst_n)
    (ev_ok && s_r.state == ST_ACKR && scl_rise && sda_s)
      |=> (s_r.state == ST_SKIP && !s_r.sda_oe))
    else $error("read not abandoned on nack");

  a_stop_release: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && stop_c) |=> (!s_r.sda_oe && s_r.state == ST_IDLE && !s_r.hs))
    else $error("stop did not release the port");

  a_res_sat: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && conv_valid && !in_range)
      |=> (s_r.res == `ADC_RES_POS_FS || s_r.res == `ADC_RES_NEG_FS))
    else $error("result wrapped instead of saturating");

  a_res_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !conv_valid |=> $stable(s_r.res))
    else $error("result changed without a conversion");

  a_ptr_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.state != ST_WR) |=> $stable(s_r.ptr))
    else $error("pointer changed outside a write");

  a_hs_nack: assert property (@(posedge clk) disable iff (!arst_n)
    (ev_ok && s_r.state == ST_ADDR && scl_fall && s_r.cnt == 4'h8
     && s_r.sh[7:3] == `ADC_HS_CODE) |=> (!s_r.sda_oe && s_r.hs))
    else $error("master code acknowledged or mode not entered");

  a_idle_out: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && !stop_c && !start_c && s_r.idle_cnt > 32'(TIMEOUT_CYC))
      |=> (s_r.state == ST_IDLE && !s_r.sda_oe))
    else $error("bus timeout did not return to idle");
endmodule // adc_i2c_slave
`default_nettype wire

// >>> testbench/adc_i2c_master.sv
// Purpose: Bus master model for the converter's two-wire port
// Assumes: Bus period 8 clk, data line pulled up
// Notes:   Clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module adc_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Also serves as repeated start; leaves the clock low
  task automatic start();
    sda_low = 1'b0;
    gap(2);
    scl = 1'b1;
    gap(2);
    sda_low = 1'b1;
    gap(2);
    scl = 1'b0;
    gap(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    gap(2);
    scl = 1'b1;
    gap(2);
    sda_low = 1'b0;
    gap(4);
  endtask
  task automatic bit_io(input logic tx, output logic rx);
    sda_low = ~tx;
    gap(2);
    scl = 1'b1;
    gap(2);
    rx = sda;
    gap(2);
    scl = 1'b0;
    gap(2);
  endtask
  // Line released in the ack slot so the device can answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule // adc_i2c_master
`default_nettype wire

// >>> testbench/test_i2c_adc_register_access.sv
// Purpose: Self-checking bench of the converter's two-wire slave port
// Assumes: Short bus timeout parameter for simulation
// Notes:   Master model sits on the far side of the data line
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"
module test_i2c_adc_register_access;
  import adc_pkg::*;
  localparam int RW = 26;
  logic                 clk, arst_n, ce, scl, m_low, sda_o, sda_oe;
  logic                 strap_bit_next, strap_bit_lsb, cv, hs, gcr;
  logic                 gc_seen = 1'b0;
  logic signed [RW-1:0] raw;
  logic [23:0]          res;
  adc_regs_t            regs;
  int                   bad_count, compares;
  int                   cyc = 0;
  wire logic            sda = ~(sda_oe | m_low);

  adc_i2c_slave #(.RAW_W(RW), .TIMEOUT_CYC(200)) dut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .strap_bit_next(strap_bit_next), .strap_bit_lsb(strap_bit_lsb),
    .conv_valid(cv), .conv_raw(raw), .result(res), .regs(regs), .hs_mode(hs),
    .gc_reset(gcr));
  adc_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulse is one cycle wide, so keep a sticky copy
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (gcr) gc_seen <= 1'b1;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] adr(input logic rd);
    return {5'b10010, strap_bit_next, strap_bit_lsb, rd};
  endfunction
  task automatic wreg(input logic [1:0] p, input logic [15:0] d, input logic data);
    logic a;
    m.start();
    m.wbyte(adr(1'b0), a);
    check(a, 1'b1);
    m.wbyte({6'h00, p}, a);
    check(a, 1'b1);
    if (data) begin
      m.wbyte(d[15:8], a);
      check(a, 1'b1);
      m.wbyte(d[7:0], a);
      check(a, 1'b1);
    end
    m.stop();
  endtask
  task automatic rd(input int n, output logic [23:0] v);
    logic a;
    logic [7:0] b;
    v = '0;
    m.start();
    m.wbyte(adr(1'b1), a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, b);
      v = {v[15:0], b};
    end
    m.gap(6);
    check(sda_oe, 1'b0);
    m.stop();
  endtask
  task automatic t_reset();
    logic [23:0] v;
    check(res, 24'h00_0000);
    check(regs, {16'h8583, 16'h8000, 16'h7FFF});
    check(sda_o, 1'b0);
    rd(3, v);
    check(v, 24'h00_0000);
  endtask
  // Stall the clock while the device holds the line low
  task automatic t_timeout();
    logic a;
    m.start();
    m.wbyte(adr(1'b1), a);
    m.gap(8);
    check(sda_oe, 1'b1);
    m.gap(300);
    check(sda_oe, 1'b0);
    m.stop();
  endtask
  task automatic t_rw();
    logic [23:0] v;
    wreg(`ADC_PTR_CFG, 16'hABCD, 1'b1);
    check(regs.cfg, 16'hABCD);
    rd(2, v);
    check(v, 24'h00_ABCD);
    rd(1, v);
    check(v, 24'h00_00AB);
    wreg(`ADC_PTR_LOW, 16'h1234, 1'b1);
    wreg(`ADC_PTR_HIGH, 16'h5678, 1'b1);
    check(regs, {16'hABCD, 16'h1234, 16'h5678});
    wreg(`ADC_PTR_LOW, 16'h0000, 1'b0);
    rd(2, v);
    check(v, 24'h00_1234);
    wreg(`ADC_PTR_RESULT, 16'hFFFF, 1'b1);
    check(res, 24'h00_0000);
  endtask
  task automatic t_conv();
    int          in_v [6] = '{16777216, 8388607, -1, -8388608, -8388613, 1193046};
    logic [23:0] ex [6]   = '{24'h7F_FFFF, 24'h7F_FFFF, 24'hFF_FFFF, 24'h80_0000,
                              24'h80_0000, 24'h12_3456};
    logic [23:0] v;
    for (int i = 0; i < 6; i++) begin
      cv  = 1'b1;
      raw = RW'(in_v[i]);
      @(negedge clk);
      cv = 1'b0;
      @(negedge clk);
      check(res, ex[i]);
    end
    // Enable low must freeze the result even with a pulse present
    ce  = 1'b0;
    cv  = 1'b1;
    raw = RW'(5);
    repeat (2) @(negedge clk);
    cv = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    check(res, 24'h12_3456);
    rd(3, v);
    check(v, 24'h12_3456);
  endtask
  // Every strap setting against every address of the family
  task automatic t_addr();
    logic a;
    for (int s = 0; s < 4; s++) begin
      {strap_bit_next, strap_bit_lsb} = 2'(s);
      for (int t = 0; t < 4; t++) begin
        m.start();
        m.wbyte({5'b10010, 2'(t), 1'b0}, a);
        check(a, t == s);
        m.stop();
      end
    end
    {strap_bit_next, strap_bit_lsb} = 2'b00;
  endtask
  task automatic t_hs();
    logic a;
    m.start();
    m.wbyte(8'h0B, a);
    check(a, 1'b0);
    check(hs, 1'b1);
    m.stop();
    check(hs, 1'b0);
  endtask
  task automatic t_gc();
    logic a;
    m.start();
    m.wbyte(8'h00, a);
    check(a, 1'b1);
    m.wbyte(8'h06, a);
    check(a, 1'b1);
    m.stop();
    check(gc_seen, 1'b1);
    check(regs, {16'h8583, 16'h8000, 16'h7FFF});
  endtask
  initial begin
    arst_n         = 1'b0;
    ce             = 1'b1;
    strap_bit_next = 1'b0;
    strap_bit_lsb  = 1'b0;
    cv             = 1'b0;
    raw            = '0;
    bad_count      = 0;
    compares       = 0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_timeout();
    t_rw();
    t_conv();
    t_addr();
    t_hs();
    t_gc();
    give_verdict();
  end
endmodule // test_i2c_adc_register_access
`default_nettype wire
